// ---- verilog/rivm_vector_map.sv ----
// reset and interrupt vector address generation for the processor core
`timescale 1ns/100ps
`include "rivm_defs.svh"

// What this block does
// [RULE1] one reset vector for pin, power-on, brown-out and watchdog reset, 0x000 default
// [RULE2] external requests zero and one vector to offsets 0x001 and 0x002
// [RULE3] pin-change groups zero to two vector to offsets 0x003 to 0x005
// [RULE4] watchdog at 0x006; second 8-bit timer A, B, overflow at 0x007-0x009
// [RULE5] 16-bit timer capture, compare A, compare B, overflow at 0x00a-0x00d
// [RULE6] first 8-bit timer compare A, compare B, overflow at 0x00e-0x010
// [RULE7] spi done at 0x011; uart receive, empty, transmit at 0x012-0x014
// [RULE8] converter, data memory, comparator, two-wire, program store at 0x015-0x019
// [RULE9] programmed boot fuse starts execution at the boot reset address
// [RULE10] table select bit moves the vector table to the boot section start
// [RULE11] relocated vector address is boot start plus the standard offset
// [RULE12] table starts at 0x001, or boot address plus 0x001 when select set
// [RULE13] fuse value 1 means reset at 0x000, value 0 means boot address
// [RULE14] reset location and table location are chosen independently
// [RULE15] software without enabled interrupts may put code in vector slots
// [RULE16] several pending requests: lowest vector number is dispatched first
module rivm_vector_map
  import rivm_pkg::*;
#(
  parameter logic [`RIVM_ADDR_W-1:0] BOOT_RESET_ADDR = `RIVM_BOOT_RESET_DEF
)
(
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     boot_reset_fuse,
  input  wire logic                     vector_table_select,
  input  wire logic                     global_int_enable,
  input  wire rivm_irq_s                irq_pending,
  input  wire logic                     vec_ack,
  output logic [`RIVM_ADDR_W-1:0]       reset_addr,
  output logic                          reset_addr_valid,
  output logic                          vec_valid,
  output logic [`RIVM_ADDR_W-1:0]       vec_addr,
  output logic [`RIVM_IDX_W-1:0]        vec_num,
  output logic [`RIVM_NUM_SRC-1:0]      irq_taken
);

  rivm_regs_s                r;
  rivm_regs_s                next_r;
  logic [`RIVM_NUM_SRC-1:0]  req_vec;
  logic                      req_any;
  logic [`RIVM_IDX_W-1:0]    req_idx;
  logic [`RIVM_ADDR_W-1:0]   std_offset;
  logic [`RIVM_ADDR_W-1:0]   table_base;

  // requests only count while the core accepts interrupts at all
  assign req_vec = global_int_enable ? irq_pending : '0;

  rivm_prio_enc u_prio (
    .req (req_vec),
    .any (req_any),
    .idx (req_idx)
  );

  // standard offset of the winning source
  always_comb
  begin
    case (req_idx)
      5'h00:   std_offset = `RIVM_OFS_EXT0;       // RULE2
      5'h01:   std_offset = `RIVM_OFS_EXT1;       // RULE2
      5'h02:   std_offset = `RIVM_OFS_PCG0;       // RULE3
      5'h03:   std_offset = `RIVM_OFS_PCG1;       // RULE3
      5'h04:   std_offset = `RIVM_OFS_PCG2;       // RULE3
      5'h05:   std_offset = `RIVM_OFS_WDOG;       // RULE4
      5'h06:   std_offset = `RIVM_OFS_T2_CMPA;    // RULE4
      5'h07:   std_offset = `RIVM_OFS_T2_CMPB;    // RULE4
      5'h08:   std_offset = `RIVM_OFS_T2_OVF;     // RULE4
      5'h09:   std_offset = `RIVM_OFS_T1_CAPT;    // RULE5
      5'h0a:   std_offset = `RIVM_OFS_T1_CMPA;    // RULE5
      5'h0b:   std_offset = `RIVM_OFS_T1_CMPB;    // RULE5
      5'h0c:   std_offset = `RIVM_OFS_T1_OVF;     // RULE5
      5'h0d:   std_offset = `RIVM_OFS_T0_CMPA;    // RULE6
      5'h0e:   std_offset = `RIVM_OFS_T0_CMPB;    // RULE6
      5'h0f:   std_offset = `RIVM_OFS_T0_OVF;     // RULE6
      5'h10:   std_offset = `RIVM_OFS_SPI_DONE;   // RULE7
      5'h11:   std_offset = `RIVM_OFS_UART_RX;    // RULE7
      5'h12:   std_offset = `RIVM_OFS_UART_EMPTY; // RULE7
      5'h13:   std_offset = `RIVM_OFS_UART_TX;    // RULE7
      5'h14:   std_offset = `RIVM_OFS_CONV_DONE;  // RULE8
      5'h15:   std_offset = `RIVM_OFS_NVDATA_RDY; // RULE8
      5'h16:   std_offset = `RIVM_OFS_COMPARATOR; // RULE8
      5'h17:   std_offset = `RIVM_OFS_TWO_WIRE;   // RULE8
      5'h18:   std_offset = `RIVM_OFS_PSTORE_RDY; // RULE8
      default: std_offset = `RIVM_OFS_EXT0;
    endcase
  end

  // table base follows the select bit only, never the fuse
  assign table_base = vector_table_select ? BOOT_RESET_ADDR : `RIVM_RESET_APP; // RULE10 RULE14

  // next-state logic
  always_comb
  begin
    next_r       = r;
    next_r.taken = '0;
    case (r.state)
      RIVM_ST_CAPTURE:
      begin
        // fuse is a strap: caught on the first edge after release, not in reset
        next_r.boot_reset_fuse = boot_reset_fuse;
        next_r.reset_valid     = 1'b1;
        if (boot_reset_fuse == `RIVM_FUSE_PROGRAMMED)
        begin
          next_r.reset_addr = BOOT_RESET_ADDR;  // RULE9 RULE13
        end
        else
        begin
          next_r.reset_addr = `RIVM_RESET_APP;  // RULE1 RULE13
        end
        next_r.state = RIVM_ST_IDLE;
      end
      RIVM_ST_IDLE:
      begin
        if (req_any)
        begin
          // RULE16
          // select bit frozen with the offer, so a late flip cannot split address and side
          next_r.vec_idx       = req_idx;
          next_r.vec_num       = req_idx + `RIVM_FIRST_VEC_NUM;
          next_r.table_in_boot = vector_table_select;
          next_r.vec_addr      = table_base + std_offset; // RULE11 RULE12
          next_r.state         = RIVM_ST_OFFER;
        end
      end
      RIVM_ST_OFFER:
      begin
        // address held until the core takes it; a withdrawn request is still served
        if (vec_ack)
        begin
          next_r.taken = `RIVM_NUM_SRC'(1) << r.vec_idx;
          next_r.state = RIVM_ST_IDLE;
        end
      end
      default:
      begin
        // stray code: fall back to idle rather than hang
        next_r.state = RIVM_ST_IDLE;
      end
    endcase
  end

  // state register; constants only under reset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r.state           <= RIVM_ST_CAPTURE;
      r.boot_reset_fuse <= `RIVM_FUSE_RESET_VAL;
      r.reset_valid     <= 1'b0;
      r.reset_addr      <= `RIVM_RESET_APP;
      r.table_in_boot   <= 1'b0;
      r.vec_idx         <= '0;
      r.vec_addr        <= '0;
      r.vec_num         <= '0;
      r.taken           <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs: data straight from the state register
  // vec_valid is a decode of the state, so it falls in the very edge that takes the ack
  assign reset_addr       = r.reset_addr;
  assign reset_addr_valid = r.reset_valid;
  assign vec_valid        = (r.state == RIVM_ST_OFFER);
  assign vec_addr         = r.vec_addr;
  assign vec_num          = r.vec_num;
  assign irq_taken        = r.taken;

  // helper: requests below the offered index when the offer was made
  // these feed the checks only and leave no logic behind in the netlist
  logic [`RIVM_NUM_SRC-1:0] below_mask;
  logic [`RIVM_ADDR_W-1:0]  std_of_idx;
  assign below_mask = (`RIVM_NUM_SRC'(1) << r.vec_idx) - `RIVM_NUM_SRC'(1);
  assign std_of_idx = `RIVM_ADDR_W'(r.vec_idx) + `RIVM_OFS_EXT0;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // unprogrammed fuse gives the shared reset vector at zero
  AST_RESET_APP: assert property ( // RULE1 RULE13
    reset_addr_valid && r.boot_reset_fuse |-> reset_addr == `RIVM_RESET_APP)
    else $error("reset address not zero with fuse unprogrammed");

  // programmed fuse gives the boot reset address
  AST_RESET_BOOT: assert property ( // RULE9 RULE13
    reset_addr_valid && !r.boot_reset_fuse |-> reset_addr == BOOT_RESET_ADDR)
    else $error("reset address not boot address with fuse programmed");

  // reset location is ready one edge after release and stays put
  AST_RESET_ONCE: assert property ( // RULE1
    $rose(reset_addr_valid) |=> reset_addr_valid && $stable(reset_addr) [*4])
    else $error("reset location not held");

  // table offset is index plus one in the application table
  AST_APP_TABLE: assert property ( // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE12
    vec_valid && !r.table_in_boot |-> vec_addr == std_of_idx)
    else $error("application vector address wrong");

  // relocated table adds boot start to the offset
  AST_BOOT_TABLE: assert property ( // RULE10 RULE11 RULE12
    vec_valid && r.table_in_boot |-> vec_addr == BOOT_RESET_ADDR + std_of_idx)
    else $error("relocated vector address wrong");

  // vector number is two above the source index
  AST_VEC_NUM: assert property ( // RULE2
    vec_valid |-> vec_num == r.vec_idx + `RIVM_FIRST_VEC_NUM)
    else $error("vector number mismatch");

  // no lower pending source was passed over
  AST_LOW_WINS: assert property ( // RULE16
    $rose(vec_valid) |-> ($past(req_vec) & below_mask) == '0
      && ($past(req_vec) & (`RIVM_NUM_SRC'(1) << r.vec_idx)) != '0)
    else $error("dispatched source was not the lowest pending");

  // table choice does not disturb the reset location
  AST_INDEPENDENT: assert property ( // RULE14
    $rose(vec_valid) |-> $stable(reset_addr) && r.table_in_boot == $past(vector_table_select))
    else $error("table and reset location coupled");

  // offer holds until taken, then one pulse for the served source
  AST_HOLD: assert property ( // RULE16
    vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr))
    else $error("offer dropped before acknowledge");

  AST_TAKEN: assert property ( // RULE16
    vec_valid && vec_ack |=> !vec_valid && irq_taken == (`RIVM_NUM_SRC'(1) << r.vec_idx)
      ##1 irq_taken == '0)
    else $error("taken pulse wrong");

  // no new offer starts while interrupts are off globally
  AST_NO_DISPATCH: assert property ( // RULE15
    !vec_valid && !global_int_enable |=> !vec_valid)
    else $error("vector offered with interrupts disabled");

  // fuse seen at the capture edge is the one kept until the next reset
  AST_FUSE_KEPT: assert property ( // RULE13
    r.state == RIVM_ST_CAPTURE |=> r.boot_reset_fuse == $past(boot_reset_fuse))
    else $error("fuse not captured at first edge");

  // the reset location is out on the edge right after capture
  AST_VALID_FIRST: assert property ( // RULE1
    r.state == RIVM_ST_CAPTURE |=> reset_addr_valid)
    else $error("reset location late");

  // nothing is offered or served before the reset location is out
  AST_CAPTURE_QUIET: assert property ( // RULE1
    r.state == RIVM_ST_CAPTURE |-> !vec_valid && irq_taken == '0)
    else $error("activity during capture");

  // the reset location never moves once it is out
  AST_RESET_STAYS: assert property ( // RULE9 RULE13
    reset_addr_valid |=> reset_addr_valid && $stable(reset_addr))
    else $error("reset location moved after capture");

  // capture happens once per reset, never again while running
  AST_CAPTURE_ONCE: assert property ( // RULE1
    reset_addr_valid |-> r.state != RIVM_ST_CAPTURE)
    else $error("fuse capture repeated");

  // an idle block with an enabled request offers on the next edge
  AST_OFFER_NEXT: assert property ( // RULE16
    r.state == RIVM_ST_IDLE && global_int_enable && irq_pending != '0 |=> vec_valid)
    else $error("pending request not offered");

  // the offered number and table side stay put until taken
  AST_OFFER_STEADY: assert property ( // RULE10 RULE12
    vec_valid && !vec_ack |=> $stable(vec_num) && $stable(r.table_in_boot))
    else $error("offer changed before acknowledge");

  // vector numbers run from two for the first source to twenty-six
  AST_NUM_RANGE: assert property ( // RULE2 RULE8
    vec_valid |-> vec_num >= `RIVM_FIRST_VEC_NUM && vec_num <= 5'h1a)
    else $error("vector number out of range");

  // every offer lands in the 25 slots that follow its table base
  AST_IN_TABLE: assert property ( // RULE11 RULE12
    vec_valid |-> ((vec_addr - (r.table_in_boot ? BOOT_RESET_ADDR : `RIVM_RESET_APP))
      inside {[12'h001:12'h019]}))
    else $error("vector address outside its table");

  // an ack seen outside an offer serves nothing
  AST_ACK_IGNORED: assert property ( // RULE16
    !vec_valid |=> irq_taken == '0)
    else $error("taken pulse without an offer");

  // a served pulse marks one source only and only after an acknowledge
  AST_TAKEN_CAUSE: assert property ( // RULE16
    irq_taken != '0 |-> $onehot(irq_taken) && $past(vec_valid && vec_ack))
    else $error("taken pulse without acknowledge");

  COV_BOOT_RESET:  cover property (reset_addr_valid && !r.boot_reset_fuse);
  COV_BOOT_TABLE:  cover property (vec_valid && r.table_in_boot && vec_ack);
  COV_TWO_PENDING: cover property ($rose(vec_valid) && $countones($past(req_vec)) > 1);
  COV_BACK2BACK:   cover property (vec_valid && vec_ack ##2 vec_valid);
  COV_SPLIT:       cover property (vec_valid && r.table_in_boot && reset_addr == `RIVM_RESET_APP);

endmodule

// ---- verilog/rivm_defs.svh ----
// constants for the reset and interrupt vector map
`ifndef RIVM_DEFS_SVH
`define RIVM_DEFS_SVH

// widths
`define RIVM_ADDR_W          12
`define RIVM_NUM_SRC         25
`define RIVM_IDX_W           5

// reset locations and fuse coding
`define RIVM_RESET_APP       12'h000
`define RIVM_BOOT_RESET_DEF  12'h800
`define RIVM_FUSE_PROGRAMMED 1'b0
`define RIVM_FUSE_RESET_VAL  1'b1

// vector number of the first interrupt source (reset is number 1)
`define RIVM_FIRST_VEC_NUM   5'h02

// standard table offsets, one per interrupt source
`define RIVM_OFS_EXT0        12'h001
`define RIVM_OFS_EXT1        12'h002
`define RIVM_OFS_PCG0        12'h003
`define RIVM_OFS_PCG1        12'h004
`define RIVM_OFS_PCG2        12'h005
`define RIVM_OFS_WDOG        12'h006
`define RIVM_OFS_T2_CMPA     12'h007
`define RIVM_OFS_T2_CMPB     12'h008
`define RIVM_OFS_T2_OVF      12'h009
`define RIVM_OFS_T1_CAPT     12'h00a
`define RIVM_OFS_T1_CMPA     12'h00b
`define RIVM_OFS_T1_CMPB     12'h00c
`define RIVM_OFS_T1_OVF      12'h00d
`define RIVM_OFS_T0_CMPA     12'h00e
`define RIVM_OFS_T0_CMPB     12'h00f
`define RIVM_OFS_T0_OVF      12'h010
`define RIVM_OFS_SPI_DONE    12'h011
`define RIVM_OFS_UART_RX     12'h012
`define RIVM_OFS_UART_EMPTY  12'h013
`define RIVM_OFS_UART_TX     12'h014
`define RIVM_OFS_CONV_DONE   12'h015
`define RIVM_OFS_NVDATA_RDY  12'h016
`define RIVM_OFS_COMPARATOR  12'h017
`define RIVM_OFS_TWO_WIRE    12'h018
`define RIVM_OFS_PSTORE_RDY  12'h019

`endif

// ---- verilog/rivm_pkg.sv ----
// types for the reset and interrupt vector map
package rivm_pkg;

  // controller sequence
  typedef enum logic [1:0] {
    RIVM_ST_CAPTURE = 2'b00,
    RIVM_ST_IDLE    = 2'b01,
    RIVM_ST_OFFER   = 2'b10
  } rivm_state_e;

  // pending requests; last field is bit 0, lowest vector number
  typedef struct packed {
    logic program_store_ready;
    logic two_wire_serial_source;
    logic comparator;
    logic nonvolatile_data_ready;
    logic conversion_done;
    logic uart_tx_done;
    logic uart_data_empty;
    logic uart_rx_done;
    logic spi_done;
    logic timer0_overflow;
    logic timer0_compare_b;
    logic timer0_compare_a;
    logic timer1_overflow;
    logic timer1_compare_b;
    logic timer1_compare_a;
    logic timer1_capture;
    logic timer2_overflow;
    logic timer2_compare_b;
    logic timer2_compare_a;
    logic watchdog_timeout_source;
    logic pin_change_group_two;
    logic pin_change_group_one;
    logic pin_change_group_zero;
    logic external_request_one;
    logic external_request_zero;
  } rivm_irq_s;

  // all state of the vector map
  typedef struct packed {
    rivm_state_e  state;
    logic         boot_reset_fuse;
    logic         reset_valid;
    logic [11:0]  reset_addr;
    logic         table_in_boot;
    logic [4:0]   vec_idx;
    logic [11:0]  vec_addr;
    logic [4:0]   vec_num;
    logic [24:0]  taken;
  } rivm_regs_s;

endpackage

// ---- verilog/rivm_prio_enc.sv ----
// lowest-index-first priority encoder for pending requests
`timescale 1ns/100ps
`include "rivm_defs.svh"
module rivm_prio_enc
  import rivm_pkg::*;
(
  input  wire logic [`RIVM_NUM_SRC-1:0] req,
  output logic                          any,
  output logic [`RIVM_IDX_W-1:0]        idx
);

  logic [`RIVM_NUM_SRC:0]   lower_seen;
  logic [`RIVM_IDX_W-1:0]   idx_chain [`RIVM_NUM_SRC:0];

  assign lower_seen[0] = 1'b0;
  assign idx_chain[0]  = '0;

  // first set bit from the bottom wins; chain keeps index of the winner
  for (genvar i = 0; i < `RIVM_NUM_SRC; i++)
  begin : g_bit
    assign lower_seen[i+1] = lower_seen[i] | req[i];
    assign idx_chain[i+1]  = (req[i] && !lower_seen[i]) ? `RIVM_IDX_W'(i) : idx_chain[i];
  end

  assign any = lower_seen[`RIVM_NUM_SRC];
  assign idx = idx_chain[`RIVM_NUM_SRC];

endmodule

// ---- sim/rivm_core_model.sv ----
// processor core stand-in that takes offered vectors
`timescale 1ns/100ps
`include "rivm_defs.svh"
module rivm_core_model
(
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic                    vec_valid,
  input  wire logic [`RIVM_ADDR_W-1:0] vec_addr,
  input  wire logic [`RIVM_IDX_W-1:0]  vec_num,
  input  wire logic [3:0]              ack_delay,
  output logic                         vec_ack,
  output logic [`RIVM_ADDR_W-1:0]      got_addr,
  output logic [`RIVM_IDX_W-1:0]       got_num,
  output logic [7:0]                   got_cnt
);
  logic [3:0] wait_cnt;

  // ack drives off the falling edge; a slow core waits ack_delay cycles
  always @(negedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vec_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (!vec_valid)
    begin
      vec_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt >= ack_delay)
      vec_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end

  // the fetch address is taken at the edge where ack is seen
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      got_addr <= 12'h000;
      got_num  <= 5'h00;
      got_cnt  <= 8'h00;
    end
    else if (vec_valid && vec_ack)
    begin
      got_addr <= vec_addr;
      got_num  <= vec_num;
      got_cnt  <= got_cnt + 8'h01;
    end
  end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the reset and interrupt vector map
`timescale 1ns/100ps
`include "rivm_defs.svh"
module tb
  import rivm_pkg::*;
;
  localparam logic [`RIVM_ADDR_W-1:0] BOOT = 12'hc00;
  logic        core_clk = 1'b0;
  logic        rstn;
  logic        fuse;
  logic        tsel;
  logic        gie;
  logic        vec_ack;
  logic        reset_addr_valid;
  logic        vec_valid;
  logic [24:0] pend;
  logic [24:0] irq_taken;
  logic [11:0] reset_addr;
  logic [11:0] vec_addr;
  logic [11:0] got_addr;
  logic [4:0]  vec_num;
  logic [4:0]  got_num;
  logic [7:0]  got_cnt;
  logic [3:0]  dly;
  int          n_fail;
  int          cmp_count;

  rivm_vector_map #(.BOOT_RESET_ADDR(BOOT)) dut (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .boot_reset_fuse     (fuse),
    .vector_table_select (tsel),
    .global_int_enable   (gie),
    .irq_pending         (rivm_irq_s'(pend)),
    .vec_ack             (vec_ack),
    .reset_addr          (reset_addr),
    .reset_addr_valid    (reset_addr_valid),
    .vec_valid           (vec_valid),
    .vec_addr            (vec_addr),
    .vec_num             (vec_num),
    .irq_taken           (irq_taken)
  );

  rivm_core_model core (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .vec_valid (vec_valid),
    .vec_addr  (vec_addr),
    .vec_num   (vec_num),
    .ack_delay (dly),
    .vec_ack   (vec_ack),
    .got_addr  (got_addr),
    .got_num   (got_num),
    .got_cnt   (got_cnt)
  );

  // 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // fuse is only looked at once, so flipping it later must not move reset
  task automatic do_reset(input logic f, input logic [11:0] exp);
    rstn = 1'b0;
    fuse = f;
    pend = '0;
    repeat (12) @(negedge core_clk);
    chk(25'(reset_addr_valid), 25'h0, "valid in reset");
    rstn = 1'b1;
    @(negedge core_clk);
    chk(25'(reset_addr_valid), 25'h1, "reset valid");
    chk(25'(reset_addr), 25'(exp), "reset addr");
    fuse = ~f;
    repeat (2) @(negedge core_clk);
    chk(25'(reset_addr), 25'(exp), "fuse resampled");
  endtask

  // wait for the core to take a vector, then judge address, number, pulse
  task automatic serve(input int idx, input logic sel);
    logic [7:0]  c0;
    logic [11:0] ea;
    c0 = got_cnt;
    ea = (sel ? BOOT : 12'h000) + 12'(idx + 1);
    for (int k = 0; k < 40 && got_cnt == c0; k++)
      @(negedge core_clk);
    chk(25'(got_cnt != c0), 25'h1, "no ack");
    chk(25'(got_addr), 25'(ea), "vector addr");
    chk(25'(got_num), 25'(idx + 2), "vector num");
    chk(irq_taken, 25'h1 << idx, "taken pulse");
    pend[idx] = 1'b0;
    @(negedge core_clk);
    chk(irq_taken, 25'h0, "taken width");
  endtask

  task automatic dispatch(input int idx, input logic sel, input logic [3:0] d);
    tsel = sel;
    dly = d;
    gie = 1'b1;
    pend = 25'h1 << idx;
    @(negedge core_clk);
    chk(25'(vec_valid), 25'h1, "offer latency");
    serve(idx, sel);
    chk(25'(vec_valid), 25'h0, "idle after ack");
  endtask

  // everything pending: masked first, then drained lowest number first
  task automatic prio_all();
    gie = 1'b0;
    tsel = 1'b1;
    dly = 4'h1;
    pend = '1;
    repeat (10)
    begin
      @(negedge core_clk);
      chk(25'(vec_valid), 25'h0, "masked");
    end
    gie = 1'b1;
    for (int i = 0; i < 25; i++)
      serve(i, 1'b1);
  endtask

  initial
  begin
    rstn = 1'b0;
    fuse = 1'b1;
    tsel = 1'b0;
    gie = 1'b0;
    pend = '0;
    dly = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    do_reset(1'b1, 12'h000);
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 25; i++)
        dispatch(i, s[0], 4'(i % 4 * 2));
    do_reset(1'b0, BOOT);
    dispatch(24, 1'b0, 4'h1);
    prio_all();
    do_reset(1'b1, 12'h000);
    dispatch(0, 1'b1, 4'h0);
    finish_test();
  end

  // the run needs well under a thousand cycles
  initial
  begin
    #2_000_000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
